//--- rtl/dvt_halt_timer.v
`timescale 1ns/100ps
`include "dvt_map.vh"

module dvt_halt_timer #(
  parameter TICKS_PER_UNIT = `DVT_TICKS_PER_UNIT,
  parameter CNT_W          = 20
) (
  input  wire             sys_clk,
  input  wire             rst,
  input  wire             bus_tick,
  input  wire             start,
  input  wire [CNT_W-1:0] units,
  output wire             busy
);

  reg [CNT_W+12:0] units_left_q;
  reg [12:0]       tick_left_q;

  // One unit is TICKS_PER_UNIT bus clocks; a restart reloads both counters
  always @(posedge sys_clk) begin
    if (rst) begin
      units_left_q <= {(CNT_W+13){1'b0}};
      tick_left_q  <= 13'h0000;
    end else if (start) begin
      units_left_q <= {13'h0000, units};
      tick_left_q  <= TICKS_PER_UNIT[12:0];
    end else if (bus_tick && units_left_q != {(CNT_W+13){1'b0}}) begin
      if (tick_left_q == 13'h0001) begin
        tick_left_q  <= TICKS_PER_UNIT[12:0];
        units_left_q <= units_left_q - {{(CNT_W+12){1'b0}}, 1'b1};
      end else begin
        tick_left_q <= tick_left_q - 13'h0001;
      end
    end
  end

  assign busy = (units_left_q != {(CNT_W+13){1'b0}});

endmodule // dvt_halt_timer

//--- rtl/dvt_map.vh
`ifndef DVT_MAP_VH
`define DVT_MAP_VH

// Offsets inside the 16-byte block
`define DVT_OFS_RSV0        4'h0
`define DVT_OFS_RSV1        4'h4
`define DVT_OFS_CTRL        4'h8
`define DVT_OFS_RSV2        4'hc

// Control field layout
`define DVT_TMO_MSB         31
`define DVT_TMO_LSB         12
`define DVT_MODE_BIT        11
`define DVT_VEN_BIT         10
`define DVT_SRC_MSB         9
`define DVT_SRC_LSB         8
`define DVT_IRC_MSB         7
`define DVT_IRC_LSB         5
`define DVT_VCV_MSB         4
`define DVT_VCV_LSB         0
`define DVT_RW_MASK         32'h00000fff

// Reset values
`define DVT_CTRL_RESET      12'h00a
`define DVT_VCODE_RESET     5'h0a

// Timing
`define DVT_TICKS_PER_UNIT  4096
`define DVT_BUS_DIV         1

// Special bus cycle encoding
`define DVT_SPC_BYTE_EN     8'hbf
`define DVT_SPC_ADDR_43     2'h0

// Ratio codes as core-to-bus ratio in half steps
`define DVT_RATIO_100       4'h4
`define DVT_RATIO_101       4'h6
`define DVT_RATIO_110       4'hc
`define DVT_RATIO_111       4'h7
`define DVT_RATIO_000       4'h9
`define DVT_RATIO_001       4'ha
`define DVT_RATIO_010       4'h8
`define DVT_RATIO_011       4'hb

`endif

//--- rtl/dvt_top.v
// Function
// RULE1 - 16-byte block, one read/write control dword at bytes 11 to 8.
// RULE2 - Bytes 15-12 and 7-0 are reserved and read as zero.
// RULE3 - Reset clears the control field except voltage code value, which becomes 01010b.
// RULE4 - Non-zero halt timeout count write enters the stop-grant state.
// RULE5 - Stop-grant lasts halt timeout count times 4096 bus clocks.
// RULE6 - Timer expiry leaves stop-grant and completes the transition.
// RULE7 - With change mode zero, new settings apply only on stop-grant entry.
// RULE8 - Voltage code enable chooses whether pins load the voltage code value on entry.
// RULE9 - Voltage code value drives the voltage code pins during reset.
// RULE10 - Divisor source 00 uses straps at reset; 1x uses internal code at entry.
// RULE11 - Source 1x copies internal ratio code into effective ratio code on entry.
// RULE12 - Effective ratio code maps to the listed core-to-bus clock ratios.
// RULE13 - At reset release, effective ratio code loads from ratio strap pins.
// RULE14 - System must not snoop the device during stop-grant.
// RULE15 - Halt timeout count is write-only and reads as zero.
// RULE16 - Firmware should set divisor source to 10 and voltage enable to one.
// RULE17 - Only aligned dword accesses are claimed; others go to the host bus.
// RULE18 - With special cycles enabled, each claimed access emits byte enables BFh cycle; code queues only one access behind a busy cycle, further ones emit none.
// RULE19 - System answers every special cycle with burst ready.
// RULE20 - With block access disabled, accesses pass to the host bus.
// RULE21 - Applied ratio and voltage persist after stop-grant until changed.
`timescale 1ns/100ps
`include "dvt_map.vh"

module dvt_top #(
  parameter TICKS_PER_UNIT = `DVT_TICKS_PER_UNIT,
  parameter BUS_DIV        = `DVT_BUS_DIV
) (
  input  wire        sys_clk,
  input  wire        rst,
  input  wire        io_valid,
  input  wire        io_write,
  input  wire [15:0] io_addr,
  input  wire [3:0]  io_byte_en,
  input  wire [31:0] io_wdata,
  output reg  [31:0] io_rdata,
  output reg         io_ack,
  output wire        io_claim,
  output wire        io_forward,
  input  wire [11:0] block_base_address,
  input  wire        block_access_enable,
  input  wire        special_cycle_enable,
  input  wire [2:0]  ratio_strap_pins,
  input  wire        burst_ready_in_n,
  output reg         spc_req,
  output wire [7:0]  byte_lane_enables_n,
  output wire [1:0]  spc_addr_43,
  output reg  [4:0]  voltage_code_pins,
  output reg  [2:0]  effective_ratio_code,
  output reg  [3:0]  ratio_half_steps,
  output wire        stop_grant_active,
  output wire        snoop_block
);

  localparam ST_IDLE = 2'b00;
  localparam ST_HALT = 2'b01;

  reg  [11:0] ctrl_q;
  reg  [1:0]  state_q;
  reg  [1:0]  state_d;
  reg  [2:0]  strap_meta_q;
  reg  [2:0]  strap_sync_q;
  reg         burst_ready_in_meta_q;
  reg         burst_ready_in_sync_q;
  reg         rst_seen_q;
  reg  [7:0]  div_cnt_q;
  reg         bus_tick_q;
  reg         spc_pend_q;
  wire        in_block;
  wire        aligned_dword;
  wire        hit;
  wire        spc_new;
  wire        wr_ctrl;
  wire        enter_halt;
  wire        timer_busy;
  wire [19:0] tmo_val;
  wire [3:0]  ofs;

  // Straps sync through reset, so the release edge sees the pins, not zero
  always @(posedge sys_clk) begin
    strap_meta_q <= ratio_strap_pins;
    strap_sync_q <= strap_meta_q;
  end

  // Pin inputs pass two flops before use
  always @(posedge sys_clk) begin
    if (rst) begin
      burst_ready_in_meta_q  <= 1'b1;
      burst_ready_in_sync_q  <= 1'b1;
    end else begin
      burst_ready_in_meta_q  <= burst_ready_in_n;
      burst_ready_in_sync_q  <= burst_ready_in_meta_q;
    end
  end

  // Bus clock enable; one tick per BUS_DIV system clocks
  always @(posedge sys_clk) begin
    if (rst) begin
      div_cnt_q  <= 8'h00;
      bus_tick_q <= 1'b0;
    end else if (div_cnt_q == BUS_DIV[7:0] - 8'h01) begin
      div_cnt_q  <= 8'h00;
      bus_tick_q <= 1'b1;
    end else begin
      div_cnt_q  <= div_cnt_q + 8'h01;
      bus_tick_q <= 1'b0;
    end
  end

  // Address decode
  assign ofs           = io_addr[3:0];
  assign in_block      = (io_addr[15:4] == block_base_address);
  assign aligned_dword = (io_addr[1:0] == 2'b00) && (io_byte_en == 4'hf); // [RULE17]
  assign hit           = io_valid && block_access_enable && in_block && aligned_dword; // [RULE20]
  assign io_claim      = hit;
  assign io_forward    = io_valid && !hit; // [RULE17] [RULE20]

  assign wr_ctrl    = hit && io_write && (ofs == `DVT_OFS_CTRL); // [RULE1]
  assign tmo_val    = io_wdata[`DVT_TMO_MSB:`DVT_TMO_LSB];
  assign enter_halt = wr_ctrl && (tmo_val != 20'h00000); // [RULE4]

  // Read path; reserved dwords and the timeout count read as zero
  always @(posedge sys_clk) begin
    if (rst) begin
      io_rdata <= 32'h00000000;
      io_ack   <= 1'b0;
    end else begin
      io_ack <= hit;
      if (hit && !io_write) begin
        if (ofs == `DVT_OFS_CTRL) begin
          io_rdata <= {20'h00000, ctrl_q}; // [RULE1] [RULE15]
        end else begin
          io_rdata <= 32'h00000000; // [RULE2]
        end
      end
    end
  end

  // Writable control bits; timeout count is never stored
  always @(posedge sys_clk) begin
    if (rst) begin
      ctrl_q <= `DVT_CTRL_RESET; // [RULE3]
    end else if (wr_ctrl) begin
      ctrl_q <= io_wdata[11:0]; // [RULE15]
    end
  end

  // Halt interval timer in bus clocks
  dvt_halt_timer #(
    .TICKS_PER_UNIT (TICKS_PER_UNIT),
    .CNT_W          (20)
  ) u_timer (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .bus_tick (bus_tick_q),
    .start    (enter_halt), // [RULE5]
    .units    (tmo_val),
    .busy     (timer_busy)
  );

  // Stop-grant state machine
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (enter_halt) begin
          state_d = ST_HALT; // [RULE4]
        end
      end
      ST_HALT: begin
        if (!timer_busy && !enter_halt) begin
          state_d = ST_IDLE; // [RULE6]
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always @(posedge sys_clk) begin
    if (rst) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  assign stop_grant_active = (state_q == ST_HALT);
  // Snooping is unsupported while halted; system logic gates snoops on this
  assign snoop_block       = stop_grant_active; // [RULE14]

  // Voltage code pins; loaded only on entry, held afterwards
  always @(posedge sys_clk) begin
    if (rst) begin
      voltage_code_pins <= `DVT_VCODE_RESET; // [RULE9]
    end else if (enter_halt && io_wdata[`DVT_VEN_BIT]) begin
      voltage_code_pins <= io_wdata[`DVT_VCV_MSB:`DVT_VCV_LSB]; // [RULE7] [RULE8] [RULE21]
    end
  end

  // Effective ratio; straps caught at first edge after reset release
  always @(posedge sys_clk) begin
    if (rst) begin
      rst_seen_q           <= 1'b0;
      effective_ratio_code <= 3'h0;
    end else if (!rst_seen_q) begin
      rst_seen_q           <= 1'b1;
      effective_ratio_code <= strap_sync_q; // [RULE10] [RULE13]
    end else if (enter_halt && io_wdata[`DVT_SRC_MSB]) begin
      effective_ratio_code <= io_wdata[`DVT_IRC_MSB:`DVT_IRC_LSB]; // [RULE7] [RULE11] [RULE21]
    end
  end

  // Ratio in half steps for the clock generator
  always @(posedge sys_clk) begin
    if (rst) begin
      ratio_half_steps <= `DVT_RATIO_000;
    end else begin
      case (effective_ratio_code) // [RULE12]
        3'h4:    ratio_half_steps <= `DVT_RATIO_100;
        3'h5:    ratio_half_steps <= `DVT_RATIO_101;
        3'h6:    ratio_half_steps <= `DVT_RATIO_110;
        3'h7:    ratio_half_steps <= `DVT_RATIO_111;
        3'h0:    ratio_half_steps <= `DVT_RATIO_000;
        3'h1:    ratio_half_steps <= `DVT_RATIO_001;
        3'h2:    ratio_half_steps <= `DVT_RATIO_010;
        3'h3:    ratio_half_steps <= `DVT_RATIO_011;
        default: ratio_half_steps <= `DVT_RATIO_000;
      endcase
    end
  end

  assign spc_new = hit && special_cycle_enable;

  // Special cycle held until burst ready; completion and a new access may coincide
  always @(posedge sys_clk) begin
    if (rst) begin
      spc_req    <= 1'b0;
      spc_pend_q <= 1'b0;
    end else if (spc_req && !burst_ready_in_sync_q) begin
      spc_req    <= spc_pend_q || spc_new; // [RULE19]
      spc_pend_q <= spc_pend_q && spc_new;
    end else if (spc_new) begin
      if (spc_req) begin
        spc_pend_q <= 1'b1;
      end else begin
        spc_req <= 1'b1; // [RULE18]
      end
    end
  end

  assign byte_lane_enables_n = spc_req ? `DVT_SPC_BYTE_EN : 8'hff; // [RULE18]
  assign spc_addr_43         = `DVT_SPC_ADDR_43;

endmodule // dvt_top

//--- testbench/dvt_monitor.sv
`timescale 1ns/100ps
module dvt_monitor #(
  parameter TICKS_PER_UNIT = 4096
) (
  input wire        sys_clk,
  input wire        rst,
  input wire        io_valid,
  input wire        io_write,
  input wire [15:0] io_addr,
  input wire [3:0]  io_byte_en,
  input wire [31:0] io_wdata,
  input wire [31:0] io_rdata,
  input wire        io_ack,
  input wire        io_claim,
  input wire        io_forward,
  input wire        block_access_enable,
  input wire        spc_req,
  input wire [7:0]  byte_lane_enables_n,
  input wire [4:0]  voltage_code_pins,
  input wire [2:0]  effective_ratio_code,
  input wire        stop_grant_active
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  wire go = io_claim && io_write && io_addr[3:0] == 4'h8 && io_wdata[31:12] != 20'h0;
  chk_ack_follows: assert property (io_claim |=> io_ack)
    else $error("no ack");
  chk_odd_fwd: assert property (io_valid && io_byte_en != 4'hf
    |-> io_forward && !io_claim)
    else $error("odd access claimed");
  chk_off_fwd: assert property (io_valid && !block_access_enable |-> io_forward)
    else $error("disabled access kept");
  chk_rsv_zero: assert property (io_claim && !io_write && io_addr[3:0] != 4'h8
    |=> io_rdata == 32'h0)
    else $error("reserved not zero");
  chk_sg_enter: assert property (go |=> stop_grant_active)
    else $error("no stop grant");
  chk_vid_load: assert property (go && io_wdata[10]
    |=> voltage_code_pins == $past(io_wdata[4:0]))
    else $error("pins not loaded");
  chk_vid_keep: assert property (go && !io_wdata[10] |=> $stable(voltage_code_pins))
    else $error("pins moved");
  chk_ratio_copy: assert property (go && io_wdata[9]
    |=> effective_ratio_code == $past(io_wdata[7:5]))
    else $error("ratio not copied");
  // Strap load on the first edge after reset is exempt
  chk_idle_hold: assert property (!go && !$past(rst)
    |=> $stable(effective_ratio_code) && $stable(voltage_code_pins))
    else $error("setting moved outside entry");
  chk_rst_vid: assert property (disable iff (1'b0) rst |=> voltage_code_pins == 5'h0a)
    else $error("reset pins wrong");
  chk_spc_bytes: assert property (spc_req |-> byte_lane_enables_n == 8'hbf)
    else $error("special lanes wrong");
  cover property (go);
  cover property ($fell(stop_grant_active));
  cover property (spc_req);
endmodule // dvt_monitor
bind dvt_top dvt_monitor #(.TICKS_PER_UNIT(TICKS_PER_UNIT)) dvt_monitor_i (.sys_clk, .rst,
  .io_valid, .io_write, .io_addr, .io_byte_en, .io_wdata, .io_rdata, .io_ack, .io_claim,
  .io_forward, .block_access_enable, .spc_req, .byte_lane_enables_n, .voltage_code_pins,
  .effective_ratio_code, .stop_grant_active);

//--- testbench/dvt_sys_model.sv
`timescale 1ns/100ps
module dvt_sys_model #(
  parameter DLY = 2
) (
  input  wire sys_clk,
  input  wire spc_req,
  input  wire snoop_block,
  output reg  burst_ready_in_n
);
  // Model never snoops, so the block flag is only observed
  wire snoop_ok = !snoop_block;
  initial begin
    burst_ready_in_n = 1'b1;
    forever begin
      @(negedge sys_clk);
      if (spc_req) begin
        repeat (DLY) @(negedge sys_clk);
        burst_ready_in_n = 1'b0;
        @(negedge sys_clk);
        burst_ready_in_n = 1'b1;
        // Wait out the sync delay; a queued cycle keeps the request up
        repeat (3) @(negedge sys_clk);
      end
    end
  end
endmodule // dvt_sys_model

//--- testbench/dvt_top_bench.sv
`timescale 1ns/100ps
module dvt_top_bench;
  reg         sys_clk, rst, io_valid, io_write, block_access_enable, special_cycle_enable;
  reg  [15:0] io_addr;
  reg  [3:0]  io_byte_en;
  reg  [31:0] io_wdata, rdv;
  reg  [2:0]  ratio_strap_pins;
  reg         ak, fw;
  wire [31:0] io_rdata;
  wire [7:0]  byte_lane_enables_n;
  wire [4:0]  voltage_code_pins;
  wire [3:0]  ratio_half_steps;
  wire [2:0]  effective_ratio_code;
  wire [1:0]  spc_addr_43;
  wire        io_ack, io_claim, io_forward, burst_ready_in_n, spc_req;
  wire        stop_grant_active, snoop_block;
  integer     error_cnt = 0, checks = 0, i, n;
  // Core-to-bus ratio in half steps, one nibble per code
  localparam [31:0] hs_tab = 32'h7c64b8a9;
  dvt_top #(.TICKS_PER_UNIT(4)) dvt_top_i (.sys_clk(sys_clk), .rst(rst), .io_valid(io_valid),
    .io_write(io_write), .io_addr(io_addr), .io_byte_en(io_byte_en), .io_wdata(io_wdata),
    .io_rdata(io_rdata), .io_ack(io_ack), .io_claim(io_claim), .io_forward(io_forward),
    .block_base_address(12'h3a5), .block_access_enable(block_access_enable),
    .special_cycle_enable(special_cycle_enable), .ratio_strap_pins(ratio_strap_pins),
    .burst_ready_in_n(burst_ready_in_n), .spc_req(spc_req),
    .byte_lane_enables_n(byte_lane_enables_n),
    .spc_addr_43(spc_addr_43), .voltage_code_pins(voltage_code_pins),
    .effective_ratio_code(effective_ratio_code), .ratio_half_steps(ratio_half_steps),
    .stop_grant_active(stop_grant_active), .snoop_block(snoop_block));
  dvt_sys_model dvt_sys_model_i (.sys_clk(sys_clk), .spc_req(spc_req), .snoop_block(snoop_block),
    .burst_ready_in_n(burst_ready_in_n));
  task chk(input [31:0] got, input [31:0] exp);
    begin
      checks = checks + 1;
      if (got !== exp) begin
        error_cnt = error_cnt + 1;
        $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task acc(input w, input [3:0] a, input [31:0] d, input [3:0] be);
    begin
      @(negedge sys_clk);
      io_valid = 1'b1;
      io_write = w;
      io_addr = {12'h3a5, a};
      io_wdata = d;
      io_byte_en = be;
      #1 fw = io_forward;
      @(negedge sys_clk);
      io_valid = 1'b0;
      ak = io_ack;
      rdv = io_rdata;
    end
  endtask
  task waitsg;
    begin
      n = 1;
      while (stop_grant_active === 1'b1 && n < 2000) begin
        @(negedge sys_clk);
        n = n + 1;
      end
    end
  endtask
  task final_report;
    begin
      $display("checks=%0d error_cnt=%0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
    end
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  initial begin
    #100000;
    error_cnt = error_cnt + 1;
    final_report;
  end
  initial begin
    rst = 1'b1;
    {io_valid, io_write, io_addr, io_wdata} = 0;
    io_byte_en = 4'hf;
    block_access_enable = 1'b1;
    special_cycle_enable = 1'b0;
    ratio_strap_pins = 3'h3;
    repeat (20) @(negedge sys_clk);
    chk(voltage_code_pins, 5'h0a);
    rst = 1'b0;
    // Ratio code loads at the first edge, half steps one edge later
    repeat (2) @(negedge sys_clk);
    chk({effective_ratio_code, ratio_half_steps}, {3'h3, 4'hb});
    acc(0, 4'h8, 0, 4'hf);
    chk(rdv, 32'h0000000a);
    for (i = 0; i < 16; i = i + 4) if (i != 8) begin
      acc(1, i, 32'hffffffff, 4'hf);
      acc(0, i, 0, 4'hf);
      chk(rdv, 32'h0);
    end
    acc(1, 4'h8, 32'h000006ea, 4'hf);
    acc(0, 4'h8, 0, 4'hf);
    chk(rdv, 32'h000006ea);
    chk({effective_ratio_code, voltage_code_pins}, {3'h3, 5'h0a});
    special_cycle_enable = 1'b1;
    for (i = 0; i < 8; i = i + 1) begin
      acc(1, 4'h8, {20'h2, 4'h6, i[2:0], 5'h05}, 4'hf);
      if (i == 0) chk({byte_lane_enables_n, spc_addr_43}, {8'hbf, 2'h0});
      chk({effective_ratio_code, voltage_code_pins}, {i[2:0], 5'h05});
      chk({stop_grant_active, snoop_block}, 2'b11);
      waitsg;
      chk(n >= 8 && n <= 11, 1);
      chk({stop_grant_active, snoop_block}, 2'b00);
      chk(ratio_half_steps, hs_tab[i*4 +: 4]);
    end
    acc(1, 4'h8, 32'h0000100a, 4'hf);
    chk({effective_ratio_code, voltage_code_pins}, {3'h7, 5'h05});
    waitsg;
    acc(0, 4'h8, 0, 4'hf);
    chk(rdv, 32'h0000000a);
    block_access_enable = 1'b0;
    acc(0, 4'h8, 0, 4'hf);
    chk({ak, fw}, 2'b01);
    block_access_enable = 1'b1;
    acc(0, 4'h8, 0, 4'h3);
    chk({ak, fw}, 2'b01);
    repeat (12) @(negedge sys_clk);
    chk(spc_req, 1'b0);
    final_report;
  end
endmodule // dvt_top_bench
